// ===== hw/burst_mode_protection_control.sv
// Purpose: burst mode entry/exit, burst pwm and fault handling
// Assumes: comparator decisions arrive asynchronously; normal pwm request and valley count on pclk
// Notes: registers over apb, zero wait states
//
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/10ps
module burst_mode_protection_control #(
  parameter int unsigned ENTRY_BLANK_CYC = burst_prot_pkg::BURST_ENTRY_BLANKING_CYC,
  parameter int unsigned OVERLOAD_BLANK_CYC = burst_prot_pkg::OVERLOAD_BLANKING_CYC
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire burst_prot_pkg::cmp_t cmp_async,
  input  wire logic [2:0]           valley_count,
  input  wire logic                 normal_gate_req,
  output logic                      gate,
  output logic                      startup_en,
  output logic                      burst_flag,
  output logic                      bias_en,
  output logic                      soft_start,
  output logic                      valley_load
);
  burst_prot_pkg::cmp_t       cmp;
  burst_prot_pkg::ctl_state_t st_ff;
  burst_prot_pkg::ctl_state_t nxt_st;
  logic [31:0] ctrl_ff;
  logic [31:0] prdata_ff;
  logic        pready_ff;
  logic        pslverr_ff;
  logic        gate_ff;
  logic        startup_ff;
  logic        bias_ff;
  logic        soft_ff;
  logic        vload_ff;
  logic        burst_ff;
  logic        maxon_block_ff;
  logic [8:0]  bp_cnt_ff;
  logic [9:0]  on_cnt_ff;
  logic        entry_done;
  logic        olp_done;
  logic        ovp_done;

  in_sync #(.W($bits(burst_prot_pkg::cmp_t))) u_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .din   (cmp_async),
    .dout  (cmp)
  );

  wire in_norm  = (st_ff == burst_prot_pkg::ST_NORMAL);
  wire in_pause = (st_ff == burst_prot_pkg::ST_BURST_PAUSE);
  wire in_run   = (st_ff == burst_prot_pkg::ST_BURST_RUN);
  wire in_burst = in_pause | in_run;
  wire in_rst   = (st_ff == burst_prot_pkg::ST_RESTART);
  wire in_latch = (st_ff == burst_prot_pkg::ST_LATCHED);
  wire burst_en  = ctrl_ff[burst_prot_pkg::CTRL_BURST_EN_BIT];
  wire switch_en = ctrl_ff[burst_prot_pkg::CTRL_SWITCH_EN_BIT];

  // entry conditions, timer restarts on any drop
  wire entry_run = in_norm & burst_en & cmp.fb_below_entry & (valley_count == burst_prot_pkg::BURST_ENTRY_VALLEY_COUNT);
  blank_timer #(.LIMIT(ENTRY_BLANK_CYC)) u_entry (
    .clk   (pclk),
    .rst_n (presetn),
    .run   (entry_run),
    .done  (entry_done)
  );
  // overload blanking, not counted in burst
  wire olp_run = in_norm & cmp.fb_overload;
  blank_timer #(.LIMIT(OVERLOAD_BLANK_CYC)) u_olp (
    .clk   (pclk),
    .rst_n (presetn),
    .run   (olp_run),
    .done  (olp_done)
  );
  wire ovp_run = (in_norm | in_burst) & ~gate_ff & cmp.zc_overvoltage;
  blank_timer #(.LIMIT(burst_prot_pkg::OUTPUT_OVERVOLTAGE_BLANKING_CYC)) u_ovp (
    .clk   (pclk),
    .rst_n (presetn),
    .run   (ovp_run),
    .done  (ovp_done)
  );

  // latching faults, short winding outside burst
  wire latch_evt   = (in_norm | in_burst) & (ovp_done | (in_norm & gate_ff & cmp.cs_short_winding));
  wire supply_bad  = cmp.vcc_undervoltage | cmp.vcc_overvoltage;
  wire restart_evt = (in_norm | in_burst) & (supply_bad | (in_norm & (olp_done | cmp.over_temp)));
  wire power_up    = in_rst & startup_ff & cmp.vcc_above_on;
  wire latch_clear = in_latch & cmp.vcc_below_power_down;

  always_comb begin
    nxt_st = st_ff;
    unique case (st_ff)
      burst_prot_pkg::ST_RESTART: begin
        if (power_up) nxt_st = burst_prot_pkg::ST_NORMAL;
      end
      burst_prot_pkg::ST_NORMAL: begin
        if (latch_evt) nxt_st = burst_prot_pkg::ST_LATCHED;
        else if (restart_evt) nxt_st = burst_prot_pkg::ST_RESTART;
        else if (entry_done) nxt_st = burst_prot_pkg::ST_BURST_PAUSE;
      end
      burst_prot_pkg::ST_BURST_PAUSE: begin
        if (latch_evt) nxt_st = burst_prot_pkg::ST_LATCHED;
        else if (restart_evt) nxt_st = burst_prot_pkg::ST_RESTART;
        else if (cmp.fb_above_exit) nxt_st = burst_prot_pkg::ST_NORMAL;
        else if (cmp.fb_above_resume) nxt_st = burst_prot_pkg::ST_BURST_RUN;
      end
      burst_prot_pkg::ST_BURST_RUN: begin
        if (latch_evt) nxt_st = burst_prot_pkg::ST_LATCHED;
        else if (restart_evt) nxt_st = burst_prot_pkg::ST_RESTART;
        else if (cmp.fb_above_exit) nxt_st = burst_prot_pkg::ST_NORMAL;
        else if (cmp.fb_below_pause) nxt_st = burst_prot_pkg::ST_BURST_PAUSE;
      end
      burst_prot_pkg::ST_LATCHED: begin
        if (latch_clear) nxt_st = burst_prot_pkg::ST_RESTART;
      end
      default: nxt_st = burst_prot_pkg::ST_RESTART;
    endcase
  end

  wire period_last  = (bp_cnt_ff == 9'(burst_prot_pkg::BURST_PERIOD_CYC - 1));
  wire period_start = in_run & (bp_cnt_ff == 9'h000);
  wire [8:0] nxt_bp_cnt = (!in_run || period_last) ? 9'h000 : bp_cnt_ff + 9'h001;
  wire max_hit   = gate_ff & (on_cnt_ff == 10'(burst_prot_pkg::MAX_ON_CYC - 1));
  wire duty_hit  = gate_ff & (on_cnt_ff == 10'(burst_prot_pkg::BURST_MAX_ON_CYC - 1));
  wire [9:0] nxt_on_cnt = gate_ff ? on_cnt_ff + 10'h001 : 10'h000;
  wire gate_norm  = normal_gate_req & ~maxon_block_ff & ~max_hit;
  wire gate_burst = gate_ff ? ~(cmp.cs_burst_peak | duty_hit | max_hit) : period_start;
  wire nxt_gate = switch_en & ((in_norm & (nxt_st == burst_prot_pkg::ST_NORMAL) & gate_norm) |
                               (in_run & (nxt_st == burst_prot_pkg::ST_BURST_RUN) & gate_burst));
  wire nxt_maxon_block = (in_norm & max_hit) | (maxon_block_ff & normal_gate_req);
  // startup cell follows supply in off states
  wire off_state   = (nxt_st == burst_prot_pkg::ST_RESTART) | (nxt_st == burst_prot_pkg::ST_LATCHED);
  wire nxt_startup = off_state & (cmp.vcc_below_off | (startup_ff & ~cmp.vcc_above_on) | (startup_ff & in_rst & ~power_up));
  wire nxt_bias = (nxt_st == burst_prot_pkg::ST_NORMAL) | (nxt_st == burst_prot_pkg::ST_BURST_RUN);
  wire nxt_vload = in_burst & (nxt_st == burst_prot_pkg::ST_NORMAL);
  wire nxt_soft  = power_up;
  wire nxt_burst = (nxt_st == burst_prot_pkg::ST_BURST_PAUSE) | (nxt_st == burst_prot_pkg::ST_BURST_RUN);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff          <= burst_prot_pkg::ST_RESTART;
      gate_ff        <= 1'b0;
      startup_ff     <= 1'b1;
      bias_ff        <= 1'b0;
      soft_ff        <= 1'b0;
      vload_ff       <= 1'b0;
      burst_ff       <= 1'b0;
      maxon_block_ff <= 1'b0;
      bp_cnt_ff      <= 9'h000;
      on_cnt_ff      <= 10'h000;
    end else begin
      st_ff          <= nxt_st;
      gate_ff        <= nxt_gate;
      startup_ff     <= nxt_startup;
      bias_ff        <= nxt_bias;
      soft_ff        <= nxt_soft;
      vload_ff       <= nxt_vload;
      burst_ff       <= nxt_burst;
      maxon_block_ff <= nxt_maxon_block;
      bp_cnt_ff      <= nxt_bp_cnt;
      on_cnt_ff      <= nxt_on_cnt;
    end
  end

  // apb slave, answer in the access cycle
  wire setup     = psel & ~penable;
  wire hit_ctrl  = (paddr == burst_prot_pkg::CTRL_OFS);
  wire hit_stat  = (paddr == burst_prot_pkg::STATUS_OFS);
  wire wr_ctrl   = psel & penable & pready_ff & pwrite & hit_ctrl;
  wire [31:0] status_word = (32'(st_ff) << burst_prot_pkg::STATUS_STATE_LSB) |
                            (32'(gate_ff) << burst_prot_pkg::STATUS_GATE_BIT) |
                            (32'(startup_ff) << burst_prot_pkg::STATUS_STARTUP_BIT) |
                            (32'(bias_ff) << burst_prot_pkg::STATUS_BIAS_BIT);
  wire [31:0] rd_word = hit_ctrl ? ctrl_ff : (hit_stat ? status_word : 32'h0000_0000);
  wire [31:0] nxt_ctrl = wr_ctrl ? (pwdata & 32'h0000_0003) : ctrl_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff    <= burst_prot_pkg::CTRL_RST;
      prdata_ff  <= 32'h0000_0000;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      ctrl_ff    <= nxt_ctrl;
      prdata_ff  <= (setup & ~pwrite) ? rd_word : 32'h0000_0000;
      pready_ff  <= setup;
      pslverr_ff <= setup & ~(hit_ctrl | (hit_stat & ~pwrite));
    end
  end

  assign prdata      = prdata_ff;
  assign pready      = pready_ff;
  assign pslverr     = pslverr_ff;
  assign gate        = gate_ff;
  assign startup_en  = startup_ff;
  assign burst_flag  = burst_ff;
  assign bias_en     = bias_ff;
  assign soft_start  = soft_ff;
  assign valley_load = vload_ff;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  entry_only_a: assert property (
    (in_norm && nxt_st == burst_prot_pkg::ST_BURST_PAUSE) |-> (entry_done && $past(entry_run)))
    else $error("burst entered without entry conditions");
  resume_a: assert property (
    (in_pause && cmp.fb_above_resume && !cmp.fb_above_exit && !latch_evt && !restart_evt) |=> (in_run && bias_ff))
    else $error("burst did not resume");
  period_a: assert property (
    ($rose(gate_ff) && $past(in_run)) |-> ($past(bp_cnt_ff) == 9'h000))
    else $error("burst turn-on off the period tick");
  duty_a: assert property (
    (in_run && gate_ff) |-> (on_cnt_ff < 10'(burst_prot_pkg::BURST_MAX_ON_CYC)))
    else $error("burst on-time above duty limit");
  pause_a: assert property (
    (in_run && cmp.fb_below_pause && !cmp.fb_above_exit && !latch_evt && !restart_evt) |=> (in_pause && !bias_ff ##1 !gate_ff))
    else $error("burst did not pause");
  exit_a: assert property (
    (in_burst && cmp.fb_above_exit && !latch_evt && !restart_evt) |=> (in_norm && valley_load ##1 !valley_load))
    else $error("burst exit without counter load");
  supply_off_a: assert property (
    (in_norm && supply_bad && !latch_evt) |=> (in_rst && !gate_ff))
    else $error("supply fault left switch on");
  latch_hold_a: assert property (
    (in_latch && !cmp.vcc_below_power_down) |=> (in_latch && !gate_ff))
    else $error("latched state released");
  max_on_a: assert property (
    gate_ff |-> (on_cnt_ff < 10'(burst_prot_pkg::MAX_ON_CYC)))
    else $error("gate high beyond max on-time");
  olp_inhibit_a: assert property (
    ($past(in_burst) && in_burst) |-> !olp_done)
    else $error("overload timer ran in burst");
  exit_flag_a: assert property (
    (in_burst && cmp.fb_above_exit && !latch_evt && !restart_evt) |=> (in_norm && !burst_flag))
    else $error("burst flag kept after exit");
  startup_cell_a: assert property (
    ((in_rst || in_latch) && cmp.vcc_below_off && !power_up) |=> startup_ff)
    else $error("startup cell not enabled");
  soft_start_a: assert property (
    power_up |=> (in_norm && soft_ff && !startup_ff))
    else $error("restart without soft start");
  overload_a: assert property (
    (in_norm && olp_done && !latch_evt) |=> in_rst)
    else $error("overload did not restart");
  overvolt_latch_a: assert property (
    ((in_norm || in_burst) && ovp_done) |=> in_latch)
    else $error("output overvoltage did not latch");
  temp_restart_a: assert property (
    (in_norm && cmp.over_temp && !latch_evt) |=> in_rst)
    else $error("over-temperature did not restart");
  short_latch_a: assert property (
    (in_norm && gate_ff && cmp.cs_short_winding) |=> in_latch)
    else $error("short winding did not latch");
  burst_faults_a: assert property (
    (in_burst && !ovp_done && !supply_bad) |=> !(in_rst || in_latch))
    else $error("inhibited fault acted in burst");
  entry_restart_a: assert property (
    !entry_run |=> !entry_done)
    else $error("entry blanking not restarted");

  burst_cycle_c: cover property (in_pause ##[1:1000] in_run ##[1:1000] in_pause);
  burst_exit_c: cover property (in_burst ##1 valley_load);
  latch_c: cover property (in_norm ##1 in_latch);
  restart_c: cover property (in_rst ##1 soft_start);
  overload_c: cover property (in_norm && olp_done ##1 in_rst);
endmodule // burst_mode_protection_control

// ===== hw/burst_prot_pkg.sv
// Purpose: shared constants and types of the burst/protection controller
// Assumes: 20 MHz pclk
// Notes: times kept in their own unit, cycle counts derived
package burst_prot_pkg;
  localparam int CLK_HZ = 20_000_000;
  localparam int CLK_PER_US = CLK_HZ / 1_000_000;
  // burst entry
  localparam int BURST_ENTRY_BLANKING_MS = 24;
  localparam int BURST_ENTRY_BLANKING_CYC = BURST_ENTRY_BLANKING_MS * (CLK_HZ / 1000);
  localparam logic [2:0] BURST_ENTRY_VALLEY_COUNT = 3'h7;
  localparam logic [2:0] VALLEY_LOAD_ON_EXIT = 3'h1;
  // burst pwm
  localparam int BURST_SWITCHING_FREQUENCY_HZ = 52_000;
  localparam int BURST_PERIOD_CYC = CLK_HZ / BURST_SWITCHING_FREQUENCY_HZ;
  localparam int BURST_MAX_DUTY_PCT = 50;
  localparam int BURST_MAX_ON_CYC = (BURST_PERIOD_CYC * BURST_MAX_DUTY_PCT) / 100;
  // protections
  localparam int OVERLOAD_BLANKING_MS = 30;
  localparam int OVERLOAD_BLANKING_CYC = OVERLOAD_BLANKING_MS * (CLK_HZ / 1000);
  localparam int OUTPUT_OVERVOLTAGE_BLANKING_NS = 1000;
  localparam int OUTPUT_OVERVOLTAGE_BLANKING_CYC = (OUTPUT_OVERVOLTAGE_BLANKING_NS * CLK_PER_US + 999) / 1000;
  localparam int MAX_ON_TIME_US = 30;
  localparam int MAX_ON_CYC = MAX_ON_TIME_US * CLK_PER_US;
  localparam int TIMER_W = 20;
  // registers
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] STATUS_OFS = 12'h004;
  localparam logic [31:0] CTRL_RST = 32'h0000_0003;
  localparam int CTRL_BURST_EN_BIT = 0;
  localparam int CTRL_SWITCH_EN_BIT = 1;
  localparam int STATUS_STATE_LSB = 0;
  localparam int STATUS_GATE_BIT = 8;
  localparam int STATUS_STARTUP_BIT = 9;
  localparam int STATUS_BIAS_BIT = 10;

  typedef enum logic [5:0] {
    ST_RESTART     = 6'h01,
    ST_NORMAL      = 6'h02,
    ST_BURST_PAUSE = 6'h04,
    ST_BURST_RUN   = 6'h08,
    ST_LATCHED     = 6'h10
  } ctl_state_t;

  // comparator decisions, all asynchronous to pclk
  typedef struct packed {
    logic fb_below_entry;
    logic fb_above_resume;
    logic fb_below_pause;
    logic fb_above_exit;
    logic fb_overload;
    logic cs_burst_peak;
    logic cs_short_winding;
    logic zc_overvoltage;
    logic over_temp;
    logic vcc_undervoltage;
    logic vcc_overvoltage;
    logic vcc_below_off;
    logic vcc_above_on;
    logic vcc_below_power_down;
  } cmp_t;
endpackage : burst_prot_pkg

// ===== hw/in_sync.sv
// Purpose: three-stage pin synchroniser with agreement filter
// Assumes: inputs asynchronous to clk
// Notes: output follows once stages two and three agree
`timescale 1ns/10ps
module in_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic s1_ff;
      logic s2_ff;
      logic s3_ff;
      logic q_ff;
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          s1_ff <= 1'b0;
          s2_ff <= 1'b0;
          s3_ff <= 1'b0;
          q_ff  <= 1'b0;
        end else begin
          s1_ff <= din[i];
          s2_ff <= s1_ff;
          s3_ff <= s2_ff;
          if (s2_ff == s3_ff) begin
            q_ff <= s3_ff;
          end
        end
      end
      assign dout[i] = q_ff;
    end
  endgenerate
endmodule // in_sync

// ===== hw/blank_timer.sv
// Purpose: blanking timer, done after LIMIT cycles of continuous run
// Assumes: run from pclk logic
// Notes: run low restarts the count
`timescale 1ns/10ps
module blank_timer #(
  parameter int unsigned LIMIT = 1
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic run,
  output logic      done
);
  localparam logic [burst_prot_pkg::TIMER_W-1:0] LAST = burst_prot_pkg::TIMER_W'(LIMIT - 1);
  logic [burst_prot_pkg::TIMER_W-1:0] cnt_ff;
  logic                               done_ff;
  wire  at_last = (cnt_ff == LAST);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff  <= '0;
      done_ff <= 1'b0;
    end else if (!run) begin
      cnt_ff  <= '0;
      done_ff <= 1'b0;
    end else if (at_last) begin
      done_ff <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end
  assign done = done_ff;
endmodule // blank_timer

// ===== test/sense_model.sv
// Purpose: current sense comparator model beside the power switch
// Assumes: gate from the controller, pclk domain
// Notes: peak_cyc zero means the peak level is never reached
`timescale 1ns/10ps
module sense_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       gate,
  input  wire logic [7:0] peak_cyc,
  output logic            cs_peak
);
  logic [7:0] on_ff;
  // current ramps while the switch is on, collapses when it opens
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      on_ff <= 8'h00;
    end else begin
      on_ff <= gate ? on_ff + ((on_ff != 8'hff) ? 8'h01 : 8'h00) : 8'h00;
    end
  end
  assign cs_peak = (peak_cyc != 8'h00) && (on_ff >= peak_cyc);
endmodule // sense_model

// ===== test/burst_mode_protection_control_tb.sv
// Purpose: self-checking bench of the burst/protection controller
// Assumes: short blanking parameters, 20 MHz pclk
// Notes: expected state and pulse counts kept by the bench model
`timescale 1ns/10ps
module burst_mode_protection_control_tb;
  localparam int EB = 20;
  localparam int OB = 30;
  localparam logic [5:0] RS = burst_prot_pkg::ST_RESTART;
  localparam logic [5:0] NM = burst_prot_pkg::ST_NORMAL;
  localparam logic [5:0] PS = burst_prot_pkg::ST_BURST_PAUSE;
  localparam logic [5:0] RN = burst_prot_pkg::ST_BURST_RUN;
  localparam logic [5:0] LT = burst_prot_pkg::ST_LATCHED;
  logic                 pclk = 0;
  logic                 presetn = 0;
  logic                 psel = 0;
  logic                 penable = 0;
  logic                 pwrite = 0;
  logic [11:0]          paddr = 12'h000;
  logic [31:0]          pwdata = 32'h0;
  logic [31:0]          prdata;
  logic                 pready;
  logic                 pslverr;
  burst_prot_pkg::cmp_t c;
  burst_prot_pkg::cmp_t cmp_w;
  logic [2:0]           valley_count = 3'h0;
  logic                 normal_gate_req = 0;
  logic [7:0]           peak_cyc = 8'h00;
  logic                 cs_pk;
  logic                 gate, startup_en, burst_flag, bias_en, soft_start, valley_load;
  logic [31:0]          rs = 32'h62e9;
  logic [31:0]          rd;
  logic                 er;
  int                   miscompares = 0;
  int                   check_count = 0;
  int                   n_ss = 0;
  int                   n_vl = 0;
  int                   e_ss = 0;
  int                   hi, per;
  logic [5:0]           m_state;

  always #25 pclk = ~pclk;
  always_comb begin
    cmp_w = c;
    cmp_w.cs_burst_peak = cs_pk;
  end
  always @(posedge pclk) begin
    n_ss <= n_ss + int'(soft_start === 1'b1);
    n_vl <= n_vl + int'(valley_load === 1'b1);
  end

  burst_mode_protection_control #(.ENTRY_BLANK_CYC(EB), .OVERLOAD_BLANK_CYC(OB)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cmp_async(cmp_w), .valley_count(valley_count), .normal_gate_req(normal_gate_req),
    .gate(gate), .startup_en(startup_en), .burst_flag(burst_flag), .bias_en(bias_en),
    .soft_start(soft_start), .valley_load(valley_load));
  sense_model partner (.pclk(pclk), .presetn(presetn), .gate(gate), .peak_cyc(peak_cyc), .cs_peak(cs_pk));

  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction

  task automatic cmp(input logic [31:0] g, input logic [31:0] e, input string m);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    cmp(n, 1, "pready wait");
  endtask

  task automatic chk(input int n, input logic [5:0] s);
    repeat (n) @(posedge pclk);
    m_state = s;
    apb(0, burst_prot_pkg::STATUS_OFS, 32'h0);
    cmp(rd[5:0], m_state, "state");
  endtask

  task automatic count_hi(input int n);
    hi = 0;
    repeat (n) begin
      @(posedge pclk);
      hi += int'(gate === 1'b1);
    end
  endtask

  task automatic pulse();
    per = 0;
    while (gate !== 1'b0 && per < 999) begin @(posedge pclk); per++; end
    while (gate !== 1'b1 && per < 1999) begin @(posedge pclk); per++; end
    hi = 0;
    per = 0;
    while (gate === 1'b1 && hi < 999) begin @(posedge pclk); hi++; per++; end
    while (gate !== 1'b1 && per < 999) begin @(posedge pclk); per++; end
  endtask

  task automatic restart();
    c.vcc_below_off <= 1;
    chk(8, RS);
    cmp(startup_en, 1, "startup on");
    c.vcc_below_off <= 0;
    c.vcc_above_on <= 1;
    e_ss++;
    chk(8, NM);
    cmp(n_ss, e_ss, "soft start");
    cmp(startup_en, 0, "startup off");
    c.vcc_above_on <= 0;
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    #(50ns * 40000);
    miscompares++;
    print_verdict();
  end

  initial begin
    c = '0;
    repeat (20) @(posedge pclk);
    presetn <= 1;
    apb(0, burst_prot_pkg::CTRL_OFS, 32'h0);
    cmp(rd, burst_prot_pkg::CTRL_RST, "ctrl reset");
    chk(0, RS);
    cmp(rd, 32'h0000_0201, "status reset");
    apb(0, 12'h008, 32'h0);
    cmp({rd[30:0], er}, 32'h1, "unmapped");
    rs = xs(rs);
    apb(1, burst_prot_pkg::STATUS_OFS, rs);
    cmp(er, 1, "status write");
    apb(1, burst_prot_pkg::CTRL_OFS, rs | 32'h3);
    apb(0, burst_prot_pkg::CTRL_OFS, 32'h0);
    cmp(rd, 32'h3, "ctrl mask");
    c.vcc_above_on <= 1;
    e_ss++;
    chk(8, NM);
    cmp(n_ss, e_ss, "first soft start");
    c.vcc_above_on <= 0;
    $display("test registers and start done");
    normal_gate_req <= 1;
    count_hi(700);
    cmp(hi, burst_prot_pkg::MAX_ON_CYC, "max on time");
    normal_gate_req <= 0;
    for (int i = 0; i < 3; i++) begin
      normal_gate_req <= 1;
      c.vcc_undervoltage <= (i == 0);
      c.vcc_overvoltage <= (i == 1);
      c.over_temp <= (i == 2);
      chk(8, RS);
      cmp(gate, 0, "gate held off");
      c.vcc_undervoltage <= 0;
      c.vcc_overvoltage <= 0;
      c.over_temp <= 0;
      normal_gate_req <= 0;
      restart();
    end
    c.fb_overload <= 1;
    repeat (OB - 10) @(posedge pclk);
    c.fb_overload <= 0;
    chk(8, NM);
    c.fb_overload <= 1;
    chk(OB + 10, RS);
    c.fb_overload <= 0;
    restart();
    $display("test faults done");
    c.fb_below_entry <= 1;
    repeat (40) begin
      @(posedge pclk);
      rs = xs(rs);
      valley_count <= (rs[2:0] == 3'h7) ? 3'h0 : rs[2:0];
    end
    chk(0, NM);
    valley_count <= burst_prot_pkg::BURST_ENTRY_VALLEY_COUNT;
    repeat (EB - 8) @(posedge pclk);
    valley_count <= 3'h6;
    repeat (2) @(posedge pclk);
    valley_count <= burst_prot_pkg::BURST_ENTRY_VALLEY_COUNT;
    chk(EB - 8, NM);
    chk(EB, PS);
    cmp({burst_flag, gate}, 2'b10, "burst entered");
    c.fb_above_resume <= 1;
    chk(8, RN);
    cmp(bias_en, 1, "bias on");
    c.fb_above_resume <= 0;
    pulse();
    pulse();
    cmp(hi, burst_prot_pkg::BURST_MAX_ON_CYC, "duty limit");
    cmp(per, burst_prot_pkg::BURST_PERIOD_CYC, "burst period");
    peak_cyc <= 8'h14;
    pulse();
    pulse();
    cmp(hi >= 20 && hi < 40, 1, "peak cut");
    peak_cyc <= 8'h00;
    c.fb_overload <= 1;
    c.over_temp <= 1;
    c.cs_short_winding <= 1;
    chk(OB + 20, RN);
    c.fb_overload <= 0;
    c.over_temp <= 0;
    c.cs_short_winding <= 0;
    c.fb_below_pause <= 1;
    chk(8, PS);
    count_hi(400);
    cmp(hi, 0, "paused gate");
    cmp(bias_en, 0, "paused bias");
    c.fb_below_pause <= 0;
    c.fb_below_entry <= 0;
    c.fb_above_exit <= 1;
    valley_count <= 3'h1;
    chk(8, NM);
    cmp({burst_flag, n_vl[30:0]}, 1, "exit and load");
    c.fb_above_exit <= 0;
    $display("test burst done");
    normal_gate_req <= 1;
    repeat (4) @(posedge pclk);
    c.cs_short_winding <= 1;
    chk(8, LT);
    c.cs_short_winding <= 0;
    normal_gate_req <= 0;
    c.vcc_below_off <= 1;
    count_hi(8);
    cmp(hi, 0, "latch gate off");
    cmp(startup_en, 1, "latch startup on");
    c.vcc_below_off <= 0;
    c.vcc_above_on <= 1;
    chk(8, LT);
    cmp(startup_en, 0, "latch startup off");
    c.vcc_above_on <= 0;
    c.vcc_below_power_down <= 1;
    chk(8, RS);
    c.vcc_below_power_down <= 0;
    restart();
    c.zc_overvoltage <= 1;
    repeat (12) @(posedge pclk);
    c.zc_overvoltage <= 0;
    chk(8, NM);
    c.zc_overvoltage <= 1;
    chk(30, LT);
    c.zc_overvoltage <= 0;
    $display("test latch done");
    print_verdict();
  end
endmodule // burst_mode_protection_control_tb
